// [common/spra_pkg.sv]
/*
 package of the serial port block: answer header bytes, sync depth,
 timing budgets and state codes. assumes a 200 MHz system clock.
*/
package spra_pkg;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SYNC_STAGES = 3;
   // output valid budget after a serial clock edge
   localparam int T_DV_NS = 450;
   localparam int T_DV_CYC = (T_DV_NS * 1000) / CLK_PERIOD_PS;
   // sync stages, filter, output flop
   localparam int OUT_LAT_CYC = SYNC_STAGES + 2;
   localparam int BYTE_BITS = 8;
   localparam int ANSWER_BITS = 32;
   localparam logic [7:0] answer_header_byte_one = 8'h19;
   localparam logic [7:0] answer_header_byte_two = 8'h55;
   localparam logic [7:0] answer_header_byte_three = 8'haa;
   localparam logic [7:0] answer_header_byte_four = 8'h55;
   localparam logic [31:0] ANSWER_WORD = {answer_header_byte_four, answer_header_byte_three,
                                          answer_header_byte_two, answer_header_byte_one};
   // pin slots in the synchroniser vector
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_CSN = 2;
   localparam int PIN_RST = 3;
   localparam int PIN_COUNT = 4;
   typedef enum logic [2:0] {
      ST_STBY = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_MACK = 3'b100,
      ST_ANS = 3'b101
   } spra_state_t;
endpackage

// [common/spra_stream_if.sv]
/*
 valid/ready byte stream between the port logic and its fifo.
 assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface spra_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [logic/spra_fifo.sv]
/*
 flip-flop fifo with valid/ready on both sides.
 assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module spra_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // fill and drain sides
   spra_stream_if.snk wr,
   spra_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("fifo depth must be a power of two, at least 2");
      end
   endgenerate

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic [AW:0] cnt_nxt;
   logic ready_r;
   wire push = wr.valid & ready_r;
   wire pop = rd.ready & (cnt_r != '0);

   assign cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
   // registered ready keeps the fill side glitch free, straight off a flop
   assign wr.ready = ready_r;
   assign rd.valid = (cnt_r != '0);
   assign rd.data = mem_r[rp_r];

   always_ff @(posedge clock) begin
      if (push) begin
         mem_r[wp_r] <= wr.data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         ready_r <= 1'b1;
      end else begin
         wp_r <= wp_r + AW'(push);
         rp_r <= rp_r + AW'(pop);
         cnt_r <= cnt_nxt;
         ready_r <= (cnt_nxt != DEPTH_C);
      end
   end
endmodule

// [logic/spra_port.sv]
/*
 serial port slave of a protected memory: start/stop, byte receive
 with acknowledge, byte send from a fifo, and the 32-bit reset answer.
 assumes all pins are asynchronous to clock and that the array logic
 reports internal writes on write_busy.
*/
`timescale 1ns/1ps
module spra_port #(
   parameter int FIFO_DEPTH = 16
) (
   // system
   input wire logic clock,
   input wire logic rst,
   // serial pins
   input wire logic scl_in,
   input wire logic cs_n_in,
   input wire logic card_rst_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // array side
   input wire logic write_busy,
   input wire logic read_mode,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic standby
);
   generate
      if (spra_pkg::OUT_LAT_CYC > spra_pkg::T_DV_CYC) begin : g_bad_clk
         $error("clock too slow for the output valid budget");
      end
   endgenerate

   // pin synchronisers: change accepted once stages two and three agree
   localparam int NP = spra_pkg::PIN_COUNT;
   wire [NP-1:0] pins_raw = {card_rst_in, cs_n_in, sda_in, scl_in};
   logic [NP-1:0] s1_r;
   logic [NP-1:0] s2_r;
   logic [NP-1:0] s3_r;
   logic [NP-1:0] filt_r;
   wire [NP-1:0] agree = ~(s2_r ^ s3_r);
   wire [NP-1:0] rise = agree & s3_r & ~filt_r;
   wire [NP-1:0] fall = agree & ~s3_r & filt_r;

   genvar gi;
   for (gi = 0; gi < NP; gi++) begin : g_sync
      // reset pin idles low; matching the idle level avoids a false edge
      localparam logic IDLE_LVL = (gi != spra_pkg::PIN_RST);
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            s1_r[gi] <= IDLE_LVL;
            s2_r[gi] <= IDLE_LVL;
            s3_r[gi] <= IDLE_LVL;
            filt_r[gi] <= IDLE_LVL;
         end else begin
            s1_r[gi] <= pins_raw[gi];
            s2_r[gi] <= s1_r[gi];
            s3_r[gi] <= s2_r[gi];
            filt_r[gi] <= agree[gi] ? s3_r[gi] : filt_r[gi];
         end
      end
   end

   // both views high: a data move landing with the clock fall is no condition
   wire scl_hi = filt_r[spra_pkg::PIN_SCL] & s3_r[spra_pkg::PIN_SCL];
   wire scl_rise = rise[spra_pkg::PIN_SCL];
   wire scl_fall = fall[spra_pkg::PIN_SCL];
   wire sda_now = s3_r[spra_pkg::PIN_SDA];
   wire cs_hi = filt_r[spra_pkg::PIN_CSN];
   wire cs_fall = fall[spra_pkg::PIN_CSN];
   wire rstp_rise = rise[spra_pkg::PIN_RST];
   wire rstp_fall = fall[spra_pkg::PIN_RST];
   // no start or stop is recognised while we own the line
   wire start_cond = fall[spra_pkg::PIN_SDA] & scl_hi & ~sda_oe;
   wire stop_cond = rise[spra_pkg::PIN_SDA] & scl_hi & ~sda_oe;

   // outgoing bytes
   spra_stream_if #(.W(8)) in_if ();
   spra_stream_if #(.W(8)) out_if ();
   assign in_if.valid = tx_valid;
   assign in_if.data = tx_data;
   assign tx_ready = in_if.ready;

   spra_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst(rst),
      .wr(in_if.snk),
      .rd(out_if.src)
   );

   spra_pkg::spra_state_t state_r;
   spra_pkg::spra_state_t state_nxt;
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic [31:0] sh_r;
   logic [31:0] sh_nxt;
   logic sda_out_r;
   logic sda_out_nxt;
   logic sda_oe_r;
   logic sda_oe_nxt;
   logic rx_valid_r;
   logic rx_valid_nxt;
   logic [7:0] rx_data_r;
   logic [7:0] rx_data_nxt;
   logic asleep_r;
   logic asleep_nxt;
   logic standby_r;
   logic pop;

   localparam logic [5:0] BYTE_LAST = 6'(spra_pkg::BYTE_BITS - 1);
   localparam logic [5:0] BYTE_END = 6'(spra_pkg::BYTE_BITS);
   localparam logic [5:0] ANS_END = 6'(spra_pkg::ANSWER_BITS);
   wire more_tx = read_mode & out_if.valid;
   assign out_if.ready = pop;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      sda_out_nxt = sda_out_r;
      sda_oe_nxt = sda_oe_r;
      rx_valid_nxt = 1'b0;
      rx_data_nxt = rx_data_r;
      asleep_nxt = asleep_r;
      pop = 1'b0;
      if (cs_hi) begin
         // deselect aborts everything, answer included
         state_nxt = spra_pkg::ST_STBY;
         sda_oe_nxt = 1'b0;
         asleep_nxt = 1'b1;
      end else if (rstp_rise && !write_busy && state_r != spra_pkg::ST_ANS) begin
         state_nxt = spra_pkg::ST_ANS;
         sh_nxt = spra_pkg::ANSWER_WORD;
         cnt_nxt = '0;
         sda_oe_nxt = 1'b0;
         asleep_nxt = 1'b0;
      end else if (start_cond) begin
         state_nxt = spra_pkg::ST_RX;
         cnt_nxt = '0;
         asleep_nxt = 1'b0;
      end else if (stop_cond) begin
         // standby itself waits on write_busy below
         state_nxt = spra_pkg::ST_STBY;
         sda_oe_nxt = 1'b0;
         cnt_nxt = '0;
         asleep_nxt = 1'b1;
      end else begin
         if (cs_fall) begin
            asleep_nxt = 1'b0;
         end
         unique case (state_r)
            spra_pkg::ST_STBY: begin
               sda_oe_nxt = 1'b0;
            end
            spra_pkg::ST_RX: begin
               if (scl_rise) begin
                  rx_data_nxt = {rx_data_r[6:0], sda_now};
                  cnt_nxt = cnt_r + 6'h01;
                  if (cnt_r == BYTE_LAST) begin
                     rx_valid_nxt = 1'b1;
                     cnt_nxt = '0;
                     state_nxt = spra_pkg::ST_RX_ACK;
                  end
               end
            end
            spra_pkg::ST_RX_ACK: begin
               if (scl_rise) begin
                  sda_out_nxt = 1'b0;
                  sda_oe_nxt = 1'b1;
               end else if (scl_fall && sda_oe_r) begin
                  sda_oe_nxt = 1'b0;
                  pop = more_tx;
                  sh_nxt = {24'h000000, out_if.data};
                  state_nxt = more_tx ? spra_pkg::ST_TX : spra_pkg::ST_RX;
               end
            end
            spra_pkg::ST_TX: begin
               if (scl_rise && cnt_r != BYTE_END) begin
                  sda_out_nxt = sh_r[7];
                  sda_oe_nxt = 1'b1;
                  sh_nxt = {sh_r[30:0], 1'b0};
                  cnt_nxt = cnt_r + 6'h01;
               end else if (scl_fall && cnt_r == BYTE_END) begin
                  sda_oe_nxt = 1'b0;
                  cnt_nxt = '0;
                  state_nxt = spra_pkg::ST_TX_MACK;
               end
            end
            spra_pkg::ST_TX_MACK: begin
               if (scl_fall) begin
                  pop = more_tx;
                  sh_nxt = {24'h000000, out_if.data};
                  state_nxt = more_tx ? spra_pkg::ST_TX : spra_pkg::ST_RX;
               end
            end
            spra_pkg::ST_ANS: begin
               if ((rstp_fall && cnt_r == '0) || (scl_fall && cnt_r != '0)) begin
                  if (cnt_r == ANS_END) begin
                     sda_oe_nxt = 1'b0;
                     state_nxt = spra_pkg::ST_STBY;
                     asleep_nxt = 1'b1;
                  end else begin
                     sda_out_nxt = sh_r[0];
                     sda_oe_nxt = 1'b1;
                     sh_nxt = {1'b0, sh_r[31:1]};
                     cnt_nxt = cnt_r + 6'h01;
                  end
               end
            end
            default: begin
               state_nxt = spra_pkg::ST_STBY;
               sda_oe_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= spra_pkg::ST_STBY;
         cnt_r <= '0;
         sh_r <= '0;
         sda_out_r <= 1'b1;
         sda_oe_r <= 1'b0;
         rx_valid_r <= 1'b0;
         rx_data_r <= '0;
         asleep_r <= 1'b1;
         standby_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         sda_out_r <= sda_out_nxt;
         sda_oe_r <= sda_oe_nxt;
         rx_valid_r <= rx_valid_nxt;
         rx_data_r <= rx_data_nxt;
         asleep_r <= asleep_nxt;
         standby_r <= asleep_nxt & ~write_busy;
      end
   end

   assign sda_out = sda_out_r;
   assign sda_oe = sda_oe_r;
   assign rx_valid = rx_valid_r;
   assign rx_data = rx_data_r;
   assign standby = standby_r;
endmodule

// [verif/spra_port_chk.sv]
/*
 pin-level assertions of the serial port.
 assumes the bind below and a single clock domain.
*/
`timescale 1ns/1ps
module spra_port_chk (
   // system
   input wire logic clock,
   input wire logic rst,
   // pins and status
   input wire logic scl_in,
   input wire logic cs_n_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic write_busy,
   input wire logic rx_valid,
   input wire logic standby
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   AST_DESEL_OFF: assert property (cs_n_in [*8] |=> !sda_oe)
      else $error("drive kept while deselected");
   AST_DESEL_STBY: assert property (
      cs_n_in [*8] ##1 (cs_n_in && !write_busy) [*2] |-> standby)
      else $error("no standby while deselected");
   AST_BUSY_AWAKE: assert property (write_busy |=> !standby)
      else $error("standby during internal write");
   AST_STBY_QUIET: assert property (standby |-> !sda_oe)
      else $error("line driven in standby");
   AST_STBY_ROSE: assert property ($rose(standby) |-> !$past(write_busy))
      else $error("standby entered before write end");
   AST_RELEASE: assert property (
      $fell(sda_oe) |-> !$past(scl_in, 3) || $past(cs_n_in, 3))
      else $error("line released outside clock low");
   AST_STEADY: assert property (
      $stable(scl_in) [*8] ##1 (sda_oe && $past(sda_oe)) |-> $stable(sda_out))
      else $error("driven bit changed without clock edge");
   AST_DRIVE_SEL: assert property ($rose(sda_oe) |-> !$past(cs_n_in, 3))
      else $error("drive started while deselected");
   AST_RX_QUIET: assert property (rx_valid |-> !sda_oe ##1 !rx_valid)
      else $error("receive pulse while driving");
endmodule
bind spra_port spra_port_chk chk (.clock(clock), .rst(rst), .scl_in(scl_in),
   .cs_n_in(cs_n_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .write_busy(write_busy), .rx_valid(rx_valid), .standby(standby));

// [verif/spra_master.sv]
/*
 bus master model: select, reset pin, serial clock and data line.
 assumes the port's oe/out pair and a pull-up on the data line.
*/
`timescale 1ns/1ps
module spra_master (
   // device drive of the data line
   input wire logic sda_out,
   input wire logic sda_oe,
   // master pins
   output logic scl,
   output logic cs_n,
   output logic card_rst,
   output logic sda
);
   localparam real H = 62.5;
   logic m_oe = 1'b0;
   logic m_out = 1'b1;
   // wired-and: contention shows the low party, idle is pulled up
   assign sda = (sda_oe ? sda_out : 1'b1) & (m_oe ? m_out : 1'b1);
   initial begin
      scl = 1'b1;
      cs_n = 1'b1;
      card_rst = 1'b0;
   end
   task automatic sel(input logic v);
      cs_n = v;
      #200;
   endtask
   task automatic rst_pulse();
      scl = 1'b0;
      #500;
      card_rst = 1'b1;
      #1500;
      card_rst = 1'b0;
      #500;
   endtask
   // start (1,0) or stop (0,1); callers use it only when the device is quiet
   task automatic cond(input logic first, input logic second);
      scl = 1'b0;
      #H;
      m_oe = 1'b1;
      m_out = first;
      #H;
      scl = 1'b1;
      #H;
      m_out = second;
      #H;
      m_oe = !second;
      scl = second;
   endtask
   // answer clocking: 500 ns phases, bit read at the 450 ns valid limit
   task automatic slow_clk(output logic lo);
      #450;
      lo = sda;
      #50;
      scl = 1'b1;
      #500;
      scl = 1'b0;
   endtask
   // one clock; try pulses the line low then high while clock is high
   // data moves half a low phase after the fall; only a try pulse moves it on the clock rise
   task automatic clk(input logic drv, input logic v, input logic try,
                      output logic lo, output logic hi);
      #(H / 2);
      m_oe = drv | try;
      m_out = v;
      #(H / 2);
      lo = sda;
      scl = 1'b1;
      m_out = v & !try;
      #(H / 2);
      m_out = v;
      #(H / 2);
      hi = sda;
      scl = 1'b0;
   endtask
endmodule

// [verif/spra_port_bench.sv]
/*
 bench of the serial port: reset answer, abort, write and read.
 assumes the master model on the pins and the bound checker.
*/
`timescale 1ns/1ps
module spra_port_bench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic write_busy = 1'b0;
   logic read_mode = 1'b0;
   logic tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic scl, cs_n, card_rst, sda, sda_out, sda_oe, tx_ready, rx_valid, standby;
   logic [7:0] rx_data;
   int mismatches = 0;
   int num_checks = 0;
   int rx_count = 0;
   always #2.5 clock = ~clock;
   // receive pulses, counted mid-cycle where the flag has settled
   always @(negedge clock) begin
      if (rx_valid === 1'b1) begin
         rx_count++;
      end
   end
   spra_port dut (.clock(clock), .rst(rst), .scl_in(scl), .cs_n_in(cs_n),
      .card_rst_in(card_rst), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .write_busy(write_busy), .read_mode(read_mode), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .standby(standby));
   spra_master m (.sda_out(sda_out), .sda_oe(sda_oe), .scl(scl), .cs_n(cs_n),
      .card_rst(card_rst), .sda(sda));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, s);
      end
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic lo;
      for (int i = 7; i >= 0; i--)
         m.clk(1'b1, b[i], 1'b0, lo, ack);
      m.clk(1'b0, 1'b1, 1'b0, lo, ack);
   endtask
   // sampled at the end of clock high, 62.5 ns after the rise, well inside the output budget
   task automatic get_byte(input logic mack, input logic try, output logic [7:0] b);
      logic lo, hi;
      for (int i = 7; i >= 0; i--)
         m.clk(1'b0, 1'b1, try && i == 6, lo, b[i]);
      m.clk(1'b1, mack, 1'b0, lo, hi);
   endtask
   task automatic t_answer();
      logic [31:0] w;
      chk(32'(sda_oe), 32'h0, "reset oe");
      chk(32'(standby), 32'h1, "reset standby");
      m.sel(1'b0);
      m.rst_pulse();
      for (int i = 0; i < 32; i++)
         m.slow_clk(w[i]);
      #100;
      chk(w, 32'h55aa5519, "answer header");
      chk(32'(sda_oe), 32'h0, "answer release");
      chk(32'(standby), 32'h1, "answer standby");
   endtask
   task automatic t_abort();
      logic lo;
      m.rst_pulse();
      m.slow_clk(lo);
      chk(32'(lo), 32'h1, "abort first bit");
      m.sel(1'b1);
      chk(32'(sda_oe), 32'h0, "abort oe");
      chk(32'(standby), 32'h1, "abort standby");
      @(posedge clock);
      write_busy <= 1'b1;
      m.sel(1'b0);
      m.rst_pulse();
      chk(32'(sda_oe), 32'h0, "answer under write");
      chk(32'(standby), 32'h0, "standby under write");
      @(posedge clock);
      write_busy <= 1'b0;
   endtask
   task automatic t_write();
      logic ack;
      m.cond(1'b1, 1'b0);
      put_byte(8'h3c, ack);
      chk(32'(ack), 32'h0, "ack");
      chk(32'(rx_data), 32'h3c, "received byte");
      chk(32'(rx_count), 32'h1, "receive pulse count");
      #100;
      chk(32'(sda_oe), 32'h0, "ack release");
      @(posedge clock);
      write_busy <= 1'b1;
      m.cond(1'b0, 1'b1);
      #100;
      chk(32'(standby), 32'h0, "stop during write");
      @(posedge clock);
      write_busy <= 1'b0;
      #100;
      chk(32'(standby), 32'h1, "stop to standby");
   endtask
   // fill the fifo to refusal, then drain it; the first byte meets a stop attempt
   task automatic t_read();
      logic ack;
      logic [7:0] b;
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         tx_valid <= 1'b1;
         tx_data <= 8'h40 + 8'(i);
      end
      @(posedge clock);
      tx_valid <= 1'b0;
      read_mode <= 1'b1;
      #1;
      chk(32'(tx_ready), 32'h0, "fifo full");
      m.cond(1'b1, 1'b0);
      put_byte(8'ha1, ack);
      chk(32'(ack), 32'h0, "read ack");
      chk(32'(rx_data), 32'ha1, "command byte");
      chk(32'(rx_count), 32'h2, "command pulse count");
      for (int k = 0; k < 16; k++) begin
         get_byte(k == 15, k == 0, b);
         chk(32'(b), 32'h40 + k, "sent byte");
      end
      #100;
      chk(32'(sda_oe), 32'h0, "read release");
      chk(32'(tx_ready), 32'h1, "fifo drained");
      m.cond(1'b0, 1'b1);
      @(posedge clock);
      read_mode <= 1'b0;
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (6) @(posedge clock);
      t_answer();
      t_abort();
      t_write();
      t_read();
      end_of_test();
   end
   // whole run is some 63 us of link traffic, the slow answer clock most of it
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end
endmodule
